// *** dv/modbus_master_model.sv ***
// Request-side model of the Modbus engine feeding the data map
`timescale 1ns/1ns
module modbus_master_model
   import monitor_map_pkg::*;
(
   input  logic  mclk,
   output logic  reqValid,
   output code_t reqFunc,
   output word_t reqAddr,
   output word_t reqWrData,
   input  logic  rspValid_q,
   input  word_t rspData_q,
   input  logic  rspError_q,
   input  code_t rspExcCode_q
);
   initial {reqValid, reqFunc, reqAddr, reqWrData} = '0;
   // Calls may chain with no idle cycle, so the strobe is left high
   task xfer(input code_t f, input word_t a, input word_t d, output word_t rd, output code_t ec);
      {reqValid, reqFunc, reqAddr, reqWrData} = {1'b1, f, a, d};
      @(posedge mclk);
      #1;
      rd = rspData_q;
      ec = !rspValid_q ? 8'hEE : rspError_q ? rspExcCode_q : 8'h00;
   endtask
   // Stale address is scrambled so the map cannot lean on it
   task rest;
      reqValid = 1'b0;
      reqAddr = ~reqAddr;
   endtask
endmodule

// *** dv/monitor_map_props.sv ***
// Port-level temporal checks for the monitor data map
`timescale 1ns/1ns
module monitor_map_props
   import monitor_map_pkg::*;
(
   input logic   mclk,
   input logic   rst,
   input logic   reqValid,
   input code_t  reqFunc,
   input word_t  reqAddr,
   input word_t  unitStatus,
   input float_t errorStatus,
   input logic   newDataPulse,
   input logic   rspValid_q,
   input word_t  rspData_q,
   input logic   rspError_q,
   input code_t  rspExcCode_q,
   input logic   newDataFlag_q
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   sequence s_rd(f, a);
      reqValid && reqFunc == f && reqAddr == a;
   endsequence
   property p_answer; reqValid |=> rspValid_q; endproperty
   property p_ready; s_rd(8'h02, 16'h0000) |=> rspData_q[0] == $past(unitStatus[15]); endproperty
   property p_fatal; s_rd(8'h02, 16'h0002) |=> rspData_q[0] == $past(unitStatus[12]); endproperty
   property p_heater; s_rd(8'h02, 16'h0010) |=> rspData_q[0] == $past(errorStatus[31]); endproperty
   property p_fhi; s_rd(8'h04, 16'h0001) |=> rspData_q == $past(errorStatus[31:16]); endproperty
   property p_flo; s_rd(8'h04, 16'h0002) |=> rspData_q == $past(errorStatus[15:0]); endproperty
   property p_set; newDataPulse |=> newDataFlag_q [*2]; endproperty
   property p_clear; s_rd(8'h04, 16'h0003) ##0 !newDataPulse |=> !newDataFlag_q; endproperty
   property p_range;
      reqValid && reqFunc == 8'h04 && reqAddr > 16'h002F |=> rspError_q && rspExcCode_q == 8'h02;
   endproperty
   a_answer: assert property (p_answer) else $error("no answer after request");
   a_ready: assert property (p_ready) else $error("ready bit wrong");
   a_fatal: assert property (p_fatal) else $error("fatal bit wrong");
   a_heater: assert property (p_heater) else $error("heater bit wrong");
   a_fhi: assert property (p_fhi) else $error("fault high word wrong");
   a_flo: assert property (p_flo) else $error("fault low word wrong");
   a_set: assert property (p_set) else $error("new data flag not held");
   a_clear: assert property (p_clear) else $error("new data flag not cleared");
   a_range: assert property (p_range) else $error("bad address accepted");
endmodule
bind monitor_modbus_data_map monitor_map_props chk (.mclk(mclk), .rst(rst), .reqValid(reqValid),
   .reqFunc(reqFunc), .reqAddr(reqAddr), .unitStatus(unitStatus), .errorStatus(errorStatus),
   .newDataPulse(newDataPulse), .rspValid_q(rspValid_q), .rspData_q(rspData_q),
   .rspError_q(rspError_q), .rspExcCode_q(rspExcCode_q), .newDataFlag_q(newDataFlag_q));

// *** dv/monitor_modbus_data_map_bench.sv ***
// Self-checking bench for the monitor data map
`timescale 1ns/1ns
module monitor_modbus_data_map_bench;
   import monitor_map_pkg::*;
   logic mclk = 0, rst = 1, newDataPulse = 0, flagExp = 0;
   word_t unitStatus = '0, pressureUnit = '0, rd, reqAddr, reqWrData, rspData_q;
   float_t errorStatus = '0, fv [10] = '{default: '0};
   logic [26:0] quantityValid = '0;
   logic [2:0] strV = '0;
   logic reqValid, rspValid_q, rspError_q, newDataFlag_q;
   code_t reqFunc, rspExcCode_q, ec;
   word_t sv [6];
   integer seed = 32'h23EB, err_total = 0, tests_run = 0, cyc = 0, a;
   always #5 mclk = ~mclk;
   monitor_modbus_data_map uut (.mclk, .rst, .reqValid, .reqFunc, .reqAddr, .reqWrData,
      .unitStatus, .errorStatus, .newDataPulse, .hydrogenValue(fv[0]), .dailyTrend(fv[1]),
      .weeklyTrend(fv[2]), .monthlyTrend(fv[3]), .boardTemp(fv[4]), .fluidTemp(fv[5]),
      .humidity(fv[6]), .gaugePressure(fv[7]), .waterLevel(fv[8]), .pressureUnit,
      .pressureTrim(fv[9]), .quantityValid, .rspValid_q, .rspData_q, .rspError_q,
      .rspExcCode_q, .newDataFlag_q);
   modbus_master_model master (.mclk, .reqValid, .reqFunc, .reqAddr, .reqWrData,
      .rspValid_q, .rspData_q, .rspError_q, .rspExcCode_q);
   task chk(input word_t got, input word_t exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task rq(input code_t f, input word_t ad, input word_t d, input code_t ex);
      master.xfer(f, ad, d, rd, ec);
      chk({8'h00, ec}, {8'h00, ex});
      if (ex != 8'h00) chk(rd, 16'h0000);
   endtask
   task shake;
      unitStatus = word_t'($random(seed));
      errorStatus = $random(seed);
      pressureUnit = word_t'($random(seed));
      quantityValid = 27'($random(seed));
      foreach (fv[i]) fv[i] = $random(seed);
   endtask
   function automatic word_t ir_exp(int x);
      int k;
      k = (x >= 3 && x <= 14) ? x - 3 : (x >= 17 && x <= 22) ? x - 5 : (x >= 46) ? x - 28 : -1;
      if (x == 0) return {unitStatus[15], flagExp, unitStatus[13:0]};
      if (x == 1) return errorStatus[31:16];
      if (x == 2) return errorStatus[15:0];
      if (x == 45) return pressureUnit;
      if (k < 0) return 16'h0000;
      return k[0] ? fv[k / 2][15:0] : fv[k / 2][31:16];
   endfunction
   function automatic logic di_exp(int x);
      logic [6:0] m;
      m = {errorStatus[31:29], errorStatus[8], errorStatus[4], errorStatus[1:0]};
      if (x <= 2) return x == 1 ? flagExp : unitStatus[x == 0 ? 15 : 12];
      if (x <= 6) return unitStatus[5:3] == x - 2;
      if (x >= 16 && x <= 22) return m[22 - x];
      if (x >= 64 && x <= 66) return strV[x - 64];
      if (x == 68 || x == 72 || x == 73 || x < 48) return 1'b0;
      return quantityValid[x - 48];
   endfunction
   task tally_and_finish;
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Full run is about 405 cycles; the ceiling leaves ample slack
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 1500) begin
         err_total++;
         tally_and_finish;
      end
   end
   initial begin
      repeat (2) @(posedge mclk);
      #1 rst = 0;
      repeat (3) begin
         shake;
         for (a = 0; a <= 74; a++) begin
            rq(8'h02, a[15:0], 16'h0000, 8'h00);
            chk(rd, {15'h0000, di_exp(a)});
         end
         for (a = 0; a <= 47; a++) begin
            rq(8'h04, a[15:0], 16'h0000, 8'h00);
            chk(rd, ir_exp(a));
         end
      end
      $display("sweep test done");
      master.rest;
      newDataPulse = 1;
      @(posedge mclk);
      #1 flagExp = 1;
      // Pulse together with a data read: setting must win over clearing
      rq(8'h04, 16'h0003, 16'h0000, 8'h00);
      newDataPulse = 0;
      foreach (sv[i]) begin
         rq(8'h02, 16'h0001, 16'h0000, 8'h00);
         chk(rd, {15'h0000, flagExp});
         rq(8'h04, 16'h0016, 16'h0000, 8'h00);
         flagExp = 0;
         chk({15'h0000, newDataFlag_q}, {15'h0000, flagExp});
      end
      $display("new data test done");
      foreach (sv[b]) begin
         sv[b] = word_t'($random(seed));
         rq(8'h06, word_t'(201 + 10 * (b / 2) + 9 * (b % 2)), sv[b], 8'h00);
         chk(rd, sv[b]);
         strV[b / 2] = 1;
      end
      foreach (sv[b]) begin
         rq(8'h03, word_t'(201 + 10 * (b / 2) + 9 * (b % 2)), 16'h0000, 8'h00);
         chk(rd, sv[b]);
      end
      for (a = 64; a <= 66; a++) begin
         rq(8'h02, a[15:0], 16'h0000, 8'h00);
         chk(rd, {15'h0000, di_exp(a)});
      end
      rq(8'h06, 16'd200, 16'h1234, 8'h02);
      rq(8'h03, 16'd231, 16'h0000, 8'h02);
      rq(8'h02, 16'h004B, 16'h0000, 8'h02);
      rq(8'h04, 16'h0030, 16'h0000, 8'h02);
      rq(8'h05, 16'h0000, 16'h0000, 8'h01);
      master.rest;
      $display("string and refusal test done");
      tally_and_finish;
   end
endmodule

// *** verilog/monitor_map_pkg.sv ***
// Types shared by the monitor data map
package monitor_map_pkg;
   typedef logic [15:0] word_t;
   typedef logic [31:0] float_t;
   typedef logic [7:0]  code_t;
endpackage

// *** verilog/monitor_map_regs.svh ***
// Register addresses, field positions and response codes of the monitor data map
`ifndef MONITOR_MAP_REGS_SVH
`define MONITOR_MAP_REGS_SVH

`define FC_READ_DISCRETE    8'h02
`define FC_READ_HOLDING     8'h03
`define FC_READ_INPUT       8'h04
`define FC_WRITE_SINGLE     8'h06
`define EXC_ILLEGAL_FUNC    8'h01
`define EXC_ILLEGAL_ADDR    8'h02

`define DISCRETE_BASE_NUM   16'd10001
`define INPUT_BASE_NUM      16'd30001

`define DI_LAST             16'h004A
`define DI_VALID_FIRST      16'h0030
`define DI_OWNER_VALID      16'h0040
`define DI_SUBST_VALID      16'h0041
`define DI_XFMR_VALID       16'h0042

`define IR_UNIT_CONDITION   16'h0000
`define IR_FAULT_UPPER      16'h0001
`define IR_FAULT_LOWER      16'h0002
`define IR_HYDROGEN_UPPER   16'h0003
`define IR_DAILY_UPPER      16'h0005
`define IR_WEEKLY_UPPER     16'h0007
`define IR_MONTHLY_UPPER    16'h0009
`define IR_BOARD_UPPER      16'h000B
`define IR_FLUID_UPPER      16'h000D
`define IR_HUMIDITY_UPPER   16'h0011
`define IR_PRESSURE_UPPER   16'h0013
`define IR_WATER_UPPER      16'h0015
`define IR_PUNIT_SELECT     16'h002D
`define IR_TRIM_UPPER       16'h002E
`define IR_LAST             16'h002F

`define HR_OWNER_FIRST      16'd201
`define HR_SUBST_FIRST      16'd211
`define HR_XFMR_FIRST       16'd221
`define HR_STRING_LAST      16'd230
`define STRING_WORDS        10
`define STRING_CHARS        20

`define US_READY_BIT        15
`define US_NEW_DATA_BIT     14
`define US_FATAL_BIT        12
`define US_SENSOR_A_HI      5
`define US_SENSOR_A_LO      3
`define SA_HYDROGEN         3'h1
`define SA_FLUID_TEMP       3'h2
`define SA_AUTOCAL          3'h3
`define SA_TOO_HOT          3'h4

`define ES_HEATER_BIT       31
`define ES_TSENSE1_BIT      30
`define ES_TSENSE2_BIT      29
`define ES_RTC_BIT          8
`define ES_BOARD_HOT_BIT    4
`define ES_NO_DATA_BIT      1
`define ES_BAD_CONFIG_BIT   0

`define WORD_RESET          16'h0000

`endif

// *** verilog/monitor_modbus_data_map.sv ***
// Modbus read-side data map: discrete inputs, input registers and identification strings
//
// Contract
// - Three writable ASCII ID strings, each up to 20 characters including null.
// - Owner at holding 201-210, substation 211-220, transformer 221-230.
// - Discrete inputs read with function 2; address 0 is input 10001.
// - Discrete input 0 mirrors unit status bit 15, ready and hydrogen valid.
// - Discrete input 1 mirrors new-data bit 14; clears after data read.
// - Discrete input 2 mirrors unit status bit 12, unrecoverable error.
// - Inputs 3 to 6 decode sensor A state field, unit status bits 5-3.
// - Inputs 16, 17, 18 mirror error status bits 31, 30, 29.
// - Input 19 mirrors error status bit 8, clock date invalid.
// - Input 20 mirrors error status bit 4, board above 105 C.
// - Inputs 21 and 22 mirror error status bits 1 and 0.
// - Inputs 48 to 74 are per-quantity and per-string validity flags, except 68, 72 and 73, tied to 0.
// - Input registers read with function 4; address 0 is 30001.
// - Register 0 unit status; error status high word 1, low word 2.
// - Floats take two registers, high word first, at the listed pairs.
// - Register 45 pressure unit; pressure trim float at 46-47.
`timescale 1ns/1ns
`include "monitor_map_regs.svh"

module monitor_modbus_data_map
   import monitor_map_pkg::*;
(
   input  wire logic         mclk,
   input  wire logic         rst,
   // Request from the Modbus protocol engine, one register or bit per request
   input  wire logic         reqValid,
   input  wire code_t        reqFunc,
   input  wire word_t        reqAddr,
   input  wire word_t        reqWrData,
   // Live values from the measurement core
   input  wire word_t        unitStatus,
   input  wire float_t       errorStatus,
   input  wire logic         newDataPulse,
   input  wire float_t       hydrogenValue,
   input  wire float_t       dailyTrend,
   input  wire float_t       weeklyTrend,
   input  wire float_t       monthlyTrend,
   input  wire float_t       boardTemp,
   input  wire float_t       fluidTemp,
   input  wire float_t       humidity,
   input  wire float_t       gaugePressure,
   input  wire float_t       waterLevel,
   input  wire word_t        pressureUnit,
   input  wire float_t       pressureTrim,
   input  wire logic [26:0]  quantityValid,
   // Answer
   output logic              rspValid_q,
   output word_t             rspData_q,
   output logic              rspError_q,
   output code_t             rspExcCode_q,
   output logic              newDataFlag_q
);

   // High word sits at the lower register address
   function automatic word_t floatHalf(input float_t v, input logic lowHalf);
      floatHalf = lowHalf ? v[15:0] : v[31:16];
   endfunction

   function automatic logic inRange(input word_t a, input word_t lo, input word_t hi);
      inRange = (a >= lo) && (a <= hi);
   endfunction

   word_t       idString_q [0:29];
   logic [2:0]  stringValid_q;

   wire logic isDiscrete = reqFunc == `FC_READ_DISCRETE;
   wire logic isInput    = reqFunc == `FC_READ_INPUT;
   wire logic isHoldRd   = reqFunc == `FC_READ_HOLDING;
   wire logic isHoldWr   = reqFunc == `FC_WRITE_SINGLE;
   wire logic knownFunc  = isDiscrete | isInput | isHoldRd | isHoldWr;

   wire logic strHit     = inRange(reqAddr, `HR_OWNER_FIRST, `HR_STRING_LAST);
   wire logic [4:0] strIdx = 5'(reqAddr - `HR_OWNER_FIRST);
   wire logic [1:0] strSel = inRange(reqAddr, `HR_OWNER_FIRST, `HR_SUBST_FIRST - 16'd1) ? 2'h0 :
                             inRange(reqAddr, `HR_SUBST_FIRST, `HR_XFMR_FIRST - 16'd1)  ? 2'h1 :
                                                                                          2'h2;
   wire logic strWrite   = reqValid & isHoldWr & strHit;

   wire logic addrOk = isDiscrete ? reqAddr <= `DI_LAST :
                       isInput    ? reqAddr <= `IR_LAST :
                                    strHit;
   wire logic accept = reqValid & knownFunc & addrOk;

   // Any read of a measurement word counts as consuming the new data
   wire logic dataRead = accept & isInput &
                         inRange(reqAddr, `IR_HYDROGEN_UPPER, `IR_WATER_UPPER + 16'd1);

   wire logic [2:0] sensorA = unitStatus[`US_SENSOR_A_HI:`US_SENSOR_A_LO];

   // Live unit status with the self-clearing new-data bit substituted
   wire word_t unitLive = {unitStatus[15], newDataFlag_q, unitStatus[13:0]};

   // Validity vector for inputs 48..74; string flags for the ID strings are our own
   wire logic [26:0] validMap;
   assign validMap = {quantityValid[26],
                      2'b00,
                      quantityValid[23:21],
                      1'b0,
                      quantityValid[19],
                      stringValid_q,
                      quantityValid[15:0]};

   wire logic [74:0] discreteMap;
   assign discreteMap = {validMap,
                         25'h0,
                         errorStatus[`ES_BAD_CONFIG_BIT],
                         errorStatus[`ES_NO_DATA_BIT],
                         errorStatus[`ES_BOARD_HOT_BIT],
                         errorStatus[`ES_RTC_BIT],
                         errorStatus[`ES_TSENSE2_BIT],
                         errorStatus[`ES_TSENSE1_BIT],
                         errorStatus[`ES_HEATER_BIT],
                         9'h0,
                         sensorA == `SA_TOO_HOT,
                         sensorA == `SA_AUTOCAL,
                         sensorA == `SA_FLUID_TEMP,
                         sensorA == `SA_HYDROGEN,
                         unitStatus[`US_FATAL_BIT],
                         newDataFlag_q,
                         unitStatus[`US_READY_BIT]};

   wire logic  diBit  = discreteMap[reqAddr[6:0]];
   wire logic  lowSel = ~reqAddr[0];
   wire logic  trimLow = reqAddr[0];
   word_t      inputWord;

   always_comb begin
      case (reqAddr)
         `IR_UNIT_CONDITION:                 inputWord = unitLive;
         `IR_FAULT_UPPER:                    inputWord = errorStatus[31:16];
         `IR_FAULT_LOWER:                    inputWord = errorStatus[15:0];
         16'h0003, 16'h0004:                 inputWord = floatHalf(hydrogenValue, lowSel);
         16'h0005, 16'h0006:                 inputWord = floatHalf(dailyTrend, lowSel);
         16'h0007, 16'h0008:                 inputWord = floatHalf(weeklyTrend, lowSel);
         16'h0009, 16'h000A:                 inputWord = floatHalf(monthlyTrend, lowSel);
         16'h000B, 16'h000C:                 inputWord = floatHalf(boardTemp, lowSel);
         16'h000D, 16'h000E:                 inputWord = floatHalf(fluidTemp, lowSel);
         // Odd address is the high word here too, as for the pairs from 3 up
         16'h0011, 16'h0012:                 inputWord = floatHalf(humidity, lowSel);
         16'h0013, 16'h0014:                 inputWord = floatHalf(gaugePressure, lowSel);
         16'h0015, 16'h0016:                 inputWord = floatHalf(waterLevel, lowSel);
         `IR_PUNIT_SELECT:                   inputWord = pressureUnit;
         16'h002E, 16'h002F:                 inputWord = floatHalf(pressureTrim, trimLow);
         default:                            inputWord = `WORD_RESET;
      endcase
   end

   wire word_t answerWord = isDiscrete ? {15'h0, diBit} :
                            isInput    ? inputWord :
                            isHoldRd   ? idString_q[strIdx] :
                                         reqWrData;

   // Set wins over the read that would clear it
   wire logic newDataFlag_d = newDataPulse | (newDataFlag_q & ~dataRead);

   always_ff @(posedge mclk) begin
      if (rst) begin
         newDataFlag_q <= 1'b0;
         stringValid_q <= 3'h0;
      end else begin
         newDataFlag_q <= newDataFlag_d;
         if (strWrite) begin
            stringValid_q[strSel] <= 1'b1;
         end
      end
   end

   // 10 words of two characters each hold 20 characters with the null
   always_ff @(posedge mclk) begin
      if (rst) begin
         for (int i = 0; i < 30; i++) begin
            idString_q[i] <= `WORD_RESET;
         end
      end else if (strWrite) begin
         idString_q[strIdx] <= reqWrData;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         rspValid_q   <= 1'b0;
         rspData_q    <= `WORD_RESET;
         rspError_q   <= 1'b0;
         rspExcCode_q <= 8'h00;
      end else begin
         rspValid_q   <= reqValid;
         rspData_q    <= accept ? answerWord : `WORD_RESET;
         rspError_q   <= reqValid & ~accept;
         rspExcCode_q <= ~reqValid ? 8'h00 :
                         ~knownFunc ? `EXC_ILLEGAL_FUNC :
                         ~addrOk    ? `EXC_ILLEGAL_ADDR : 8'h00;
      end
   end

endmodule
